// ==== shared/irq_frontend_pkg.sv ====
// Constants shared by the interrupt request front end and its synchroniser.
// Assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
package irq_frontend_pkg;

    // -------------------------------------------------------------------
    // Clocking and timing
    // -------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          PROCESSOR_CLOCK_OUT_DIV     = 2;
    // Acknowledge strobe lasts one processor clock period
    localparam int          ACK_LOW_NS     = CLK_PERIOD_NS * PROCESSOR_CLOCK_OUT_DIV;
    localparam int          ACK_LOW_CYCLES = (ACK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SYNC_STAGES    = 2;

    // -------------------------------------------------------------------
    // Request inputs
    // -------------------------------------------------------------------
    localparam int          NUM_REQ        = 4;
    localparam int          NUM_SYNC       = NUM_REQ + 1;
    localparam int          NMI_BIT        = 4;
    localparam logic [7:0]  NMI_TYPE       = 8'h02;

    // -------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STATUS     = 8'h04;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h08;
    localparam logic [7:0]  OFS_REQ_ENABLE = 8'h0c;
    localparam logic [7:0]  OFS_PENDING    = 8'h10;

    // -------------------------------------------------------------------
    // Control fields
    // -------------------------------------------------------------------
    localparam int          CTRL_EDGE_LSB  = 0;
    localparam int          CTRL_ACK0_BIT  = 4;
    localparam int          CTRL_ACK1_BIT  = 5;
    localparam int          CTRL_SLAVE_BIT = 6;
    localparam int          CTRL_WIDTH     = 7;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [6:0]  CTRL_RST       = 7'h00;
    localparam logic [4:0]  STATUS_RST     = 5'h00;
    localparam logic [4:0]  IRQ_MASK_RST   = 5'h00;
    localparam logic [3:0]  REQ_ENABLE_RST = 4'h0;

    // -------------------------------------------------------------------
    // Bus responses
    // -------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

endpackage : irq_frontend_pkg

// ==== shared/pin_sync_if.sv ====
// Carrier between the front end and its input synchroniser.
// Raw side is asynchronous; synced side is on aclk.
`timescale 1ns/100ps
interface pin_sync_if #(
    parameter int WIDTH = 5
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport user (output raw, input synced);
    modport sync (input raw, output synced);
endinterface : pin_sync_if

// ==== hdl/pin_sync.sv ====
// Multi-stage synchroniser for asynchronous request pins.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH  = 5,
    parameter int STAGES = irq_frontend_pkg::SYNC_STAGES
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Pins in, synchronised levels out
    pin_sync_if.sync  pins
);

    logic [WIDTH-1:0] chain_ff [STAGES];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < STAGES; i++) begin
                chain_ff[i] <= '0;
            end
        end else begin
            chain_ff[0] <= pins.raw;
            for (int i = 1; i < STAGES; i++) begin
                chain_ff[i] <= chain_ff[i-1];
            end
        end
    end

    // Only the last stage is visible to logic
    assign pins.synced = chain_ff[STAGES-1];

endmodule : pin_sync

// ==== hdl/irq_frontend.sv ====
// External interrupt request front end: one non-maskable pin, four maskable
// request pins, two of which can turn into active-low acknowledge outputs.
// Assumes the core presents instruction boundaries on aclk and that software
// configures the block over AXI4-Lite.
//
// How it works
// - Rising edge on the non-maskable pin is synchronised, latched, raises type 2.
// - Latched non-maskable request is taken only at an instruction boundary.
// - Nothing in software can mask or disable the non-maskable request.
// - Request pins used as inputs are active high and synchronised first.
// - Pins 2 and 3 may become active-low acknowledges for requests 0 and 1.
// - Outside slave mode, each maskable input picks edge or level detection independently.
// - Slave mode changes pin functions for use under a master controller.
// - Processor clock is aclk divided by two; sampling follows it.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module irq_frontend #(
    parameter logic [7:0] INT_TYPE_BASE = 8'h0c
) (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Interrupt pins
    input  wire logic        nmi_pin,
    input  wire logic        request_pin_0,
    input  wire logic        request_pin_1_or_slave_select,
    input  wire logic        request_pin_2_in,
    output logic             request_pin_2_or_ack_out_0,
    output logic             request_pin_2_oe,
    input  wire logic        request_pin_3_in,
    output logic             request_pin_3_or_ack_out_1,
    output logic             request_pin_3_oe,
    output logic             processor_clock_out,
    // Core side
    input  wire logic        inst_boundary,
    output logic             take_valid,
    output logic [7:0]       take_type,
    // Event interrupt
    output logic             irq
);

    // -------------------------------------------------------------------
    // Register map helpers
    // -------------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        return a == irq_frontend_pkg::OFS_CTRL     || a == irq_frontend_pkg::OFS_STATUS
            || a == irq_frontend_pkg::OFS_IRQ_MASK || a == irq_frontend_pkg::OFS_REQ_ENABLE
            || a == irq_frontend_pkg::OFS_PENDING;
    endfunction : addr_mapped

    logic [6:0]  ctrl_ff;
    logic [4:0]  status_ff;
    logic [4:0]  irq_mask_ff;
    logic [3:0]  req_enable_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic        wstrb0_ff;
    logic        aw_got_ff;
    logic        w_got_ff;
    logic        wr_fire;
    logic        sts_write;
    logic [4:0]  sts_clear;

    assign wr_fire   = aw_got_ff && w_got_ff && !s_axi_bvalid;
    assign sts_write = wr_fire && wstrb0_ff && awaddr_ff == irq_frontend_pkg::OFS_STATUS;
    assign sts_clear = sts_write ? wdata_ff[4:0] : 5'h00;

    // -------------------------------------------------------------------
    // Processor clock divider
    // -------------------------------------------------------------------
    logic processor_clock_out_ff;
    logic sample_tick;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            processor_clock_out_ff <= 1'b0;
        end else begin
            processor_clock_out_ff <= ~processor_clock_out_ff;
        end
    end

    // Sample once per processor clock, at its rising edge
    assign sample_tick = !processor_clock_out_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            processor_clock_out <= 1'b0;
        end else begin
            processor_clock_out <= ~processor_clock_out_ff;
        end
    end

    // -------------------------------------------------------------------
    // Input synchronisation
    // -------------------------------------------------------------------
    pin_sync_if #(.WIDTH(irq_frontend_pkg::NUM_SYNC)) sync_bus ();

    assign sync_bus.raw = {nmi_pin, request_pin_3_in, request_pin_2_in,
                           request_pin_1_or_slave_select, request_pin_0};

    pin_sync #(
        .WIDTH  (irq_frontend_pkg::NUM_SYNC),
        .STAGES (irq_frontend_pkg::SYNC_STAGES)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (sync_bus.sync)
    );

    // -------------------------------------------------------------------
    // Sampling and detection
    // -------------------------------------------------------------------
    logic [4:0] samp_ff;
    logic [4:0] prev_ff;
    logic       ack_mode0;
    logic       ack_mode1;
    logic       slave_mode;
    logic [3:0] edge_sel;
    logic [3:0] req_used;
    logic [3:0] req_rise;
    logic       nmi_rise;

    assign ack_mode0  = ctrl_ff[irq_frontend_pkg::CTRL_ACK0_BIT];
    assign ack_mode1  = ctrl_ff[irq_frontend_pkg::CTRL_ACK1_BIT];
    assign slave_mode = ctrl_ff[irq_frontend_pkg::CTRL_SLAVE_BIT];
    // Slave mode forces level detection: the master holds its request
    assign edge_sel   = slave_mode ? 4'h0 : ctrl_ff[3:0];

    // Pins turned into outputs no longer request anything
    assign req_used = slave_mode ? 4'h1
                                 : {!ack_mode1 && !slave_mode, !ack_mode0, 2'b11};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_ff <= 5'h00;
            prev_ff <= 5'h00;
        end else if (sample_tick) begin
            samp_ff <= sync_bus.synced;
            prev_ff <= samp_ff;
        end
    end

    // Edges seen between processor-clock samples, so a pulse must span a period
    assign nmi_rise = sample_tick && samp_ff[irq_frontend_pkg::NMI_BIT]
                      && !prev_ff[irq_frontend_pkg::NMI_BIT];
    assign req_rise = {4{sample_tick}} & samp_ff[3:0] & ~prev_ff[3:0];

    // -------------------------------------------------------------------
    // Request latches
    // -------------------------------------------------------------------
    logic       nmi_pend_ff;
    logic [3:0] edge_latch_ff;
    logic [3:0] req_pend;
    logic [3:0] req_ready;
    logic       take_nmi;
    logic       take_int;
    logic [1:0] take_id;
    logic [3:0] take_onehot;

    // Level inputs are only honoured while held high
    assign req_pend  = req_used & ((edge_sel & edge_latch_ff) | (~edge_sel & samp_ff[3:0]));
    assign req_ready = req_pend & req_enable_ff;

    // Non-maskable path has no enable term at all
    assign take_nmi = inst_boundary && nmi_pend_ff;
    assign take_int = inst_boundary && !nmi_pend_ff && |req_ready;

    always_comb begin
        take_id = 2'd0;
        for (int i = irq_frontend_pkg::NUM_REQ - 1; i >= 0; i--) begin
            if (req_ready[i]) begin
                take_id = 2'(i);
            end
        end
    end

    assign take_onehot = take_int ? (4'h1 << take_id) : 4'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_pend_ff <= 1'b0;
        end else if (nmi_rise) begin
            nmi_pend_ff <= 1'b1;
        end else if (take_nmi) begin
            nmi_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_latch_ff <= 4'h0;
        end else begin
            // A fresh edge beats an acknowledge in the same cycle
            edge_latch_ff <= (edge_latch_ff & ~take_onehot) | (req_rise & edge_sel);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            take_valid <= 1'b0;
            take_type  <= 8'h00;
        end else begin
            take_valid <= take_nmi || take_int;
            if (take_nmi) begin
                take_type <= irq_frontend_pkg::NMI_TYPE;
            end else if (take_int) begin
                take_type <= INT_TYPE_BASE + {6'h00, take_id};
            end
        end
    end

    // -------------------------------------------------------------------
    // Acknowledge and slave request outputs
    // -------------------------------------------------------------------
    logic [1:0] ack_cnt0_ff;
    logic [1:0] ack_cnt1_ff;
    logic       ack_cnt_load0;
    logic       ack_cnt_load1;

    assign ack_cnt_load0 = take_onehot[0] && ack_mode0;
    assign ack_cnt_load1 = take_onehot[1] && ack_mode1 && !slave_mode;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_cnt0_ff <= 2'd0;
            ack_cnt1_ff <= 2'd0;
        end else begin
            if (ack_cnt_load0) begin
                ack_cnt0_ff <= 2'(irq_frontend_pkg::ACK_LOW_CYCLES);
            end else if (ack_cnt0_ff != 2'd0) begin
                ack_cnt0_ff <= ack_cnt0_ff - 2'd1;
            end
            if (ack_cnt_load1) begin
                ack_cnt1_ff <= 2'(irq_frontend_pkg::ACK_LOW_CYCLES);
            end else if (ack_cnt1_ff != 2'd0) begin
                ack_cnt1_ff <= ack_cnt1_ff - 2'd1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            request_pin_2_or_ack_out_0 <= 1'b1;
            request_pin_2_oe           <= 1'b0;
            request_pin_3_or_ack_out_1 <= 1'b1;
            request_pin_3_oe           <= 1'b0;
        end else begin
            request_pin_2_oe           <= ack_mode0;
            request_pin_2_or_ack_out_0 <= !(ack_cnt_load0 || ack_cnt0_ff > 2'd1);
            if (slave_mode) begin
                // Pin 3 reports a pending request upward to the master
                request_pin_3_oe           <= 1'b1;
                request_pin_3_or_ack_out_1 <= |req_ready;
            end else begin
                request_pin_3_oe           <= ack_mode1;
                request_pin_3_or_ack_out_1 <= !(ack_cnt_load1 || ack_cnt1_ff > 2'd1);
            end
        end
    end

    // -------------------------------------------------------------------
    // Event status and interrupt
    // -------------------------------------------------------------------
    logic [4:0] events;

    assign events = {nmi_rise, req_rise & req_used};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= irq_frontend_pkg::STATUS_RST;
        end else begin
            // Set wins over a write-one clear in the same cycle
            status_ff <= (status_ff & ~sts_clear) | events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((status_ff & ~sts_clear | events) & irq_mask_ff);
        end
    end

    // -------------------------------------------------------------------
    // AXI4-Lite write side
    // -------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff     <= 1'b0;
            awaddr_ff     <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff     <= 1'b1;
            awaddr_ff     <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_got_ff     <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (!aw_got_ff && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_ff     <= 1'b0;
            wdata_ff     <= 32'h0000_0000;
            wstrb0_ff    <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff     <= 1'b1;
            wdata_ff     <= s_axi_wdata;
            wstrb0_ff    <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_got_ff     <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (!w_got_ff && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= irq_frontend_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(awaddr_ff) ? irq_frontend_pkg::RESP_OKAY
                                                   : irq_frontend_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // All fields live in byte lane 0; other lanes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff       <= irq_frontend_pkg::CTRL_RST;
            irq_mask_ff   <= irq_frontend_pkg::IRQ_MASK_RST;
            req_enable_ff <= irq_frontend_pkg::REQ_ENABLE_RST;
        end else if (wr_fire && wstrb0_ff) begin
            if (awaddr_ff == irq_frontend_pkg::OFS_CTRL) begin
                ctrl_ff <= wdata_ff[irq_frontend_pkg::CTRL_WIDTH-1:0];
            end
            if (awaddr_ff == irq_frontend_pkg::OFS_IRQ_MASK) begin
                irq_mask_ff <= wdata_ff[4:0];
            end
            if (awaddr_ff == irq_frontend_pkg::OFS_REQ_ENABLE) begin
                req_enable_ff <= wdata_ff[3:0];
            end
        end
    end

    // -------------------------------------------------------------------
    // AXI4-Lite read side
    // -------------------------------------------------------------------
    logic [31:0] rd_word;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr[7:2])
            irq_frontend_pkg::OFS_CTRL[7:2]:       rd_word = {25'h0, ctrl_ff};
            irq_frontend_pkg::OFS_STATUS[7:2]:     rd_word = {27'h0, status_ff};
            irq_frontend_pkg::OFS_IRQ_MASK[7:2]:   rd_word = {27'h0, irq_mask_ff};
            irq_frontend_pkg::OFS_REQ_ENABLE[7:2]: rd_word = {28'h0, req_enable_ff};
            irq_frontend_pkg::OFS_PENDING[7:2]:    rd_word = {27'h0, nmi_pend_ff, req_pend};
            default:                               rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= irq_frontend_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= addr_mapped({s_axi_araddr[7:2], 2'b00})
                             ? irq_frontend_pkg::RESP_OKAY : irq_frontend_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : irq_frontend

// ==== dv/irq_frontend_monitor.sv ====
// Port checker for the interrupt request front end.
// Assumes it is bound to every irq_frontend instance.
`timescale 1ns/100ps
module irq_frontend_monitor #(
    parameter logic [7:0] INT_TYPE_BASE = 8'h0c
) (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Pins and core side
    input wire logic       inst_boundary,
    input wire logic       take_valid,
    input wire logic [7:0] take_type,
    input wire logic       request_pin_2_or_ack_out_0,
    input wire logic       request_pin_2_oe,
    input wire logic       request_pin_3_or_ack_out_1,
    input wire logic       processor_clock_out
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------
    // Assertions
    // ----------
    take_at_boundary_a: assert property (take_valid |-> $past(inst_boundary))
        else $error("take without boundary");
    take_kind_a: assert property (take_valid |-> take_type == 8'h02 ||
        take_type - INT_TYPE_BASE < 4) else $error("bad take type");
    ack0_cause_a: assert property ($fell(request_pin_2_or_ack_out_0) |->
        take_valid && take_type == INT_TYPE_BASE) else $error("ack0 cause");
    ack1_cause_a: assert property ($fell(request_pin_3_or_ack_out_1) |->
        take_valid && take_type == INT_TYPE_BASE + 8'h01) else $error("ack1");
    ack0_width_a: assert property ($fell(request_pin_2_or_ack_out_0) |=>
        !request_pin_2_or_ack_out_0 ##1 request_pin_2_or_ack_out_0) else $error("ack0 len");
    ack1_width_a: assert property ($fell(request_pin_3_or_ack_out_1) |=>
        !request_pin_3_or_ack_out_1 ##1 request_pin_3_or_ack_out_1) else $error("ack1 len");
    ack0_driven_a: assert property (!request_pin_2_or_ack_out_0 |-> request_pin_2_oe)
        else $error("ack0 not driven");
    clk_half_a: assert property ($past(aresetn) && $past(aresetn, 2) &&
        $past(aresetn, 3) |-> processor_clock_out != $past(processor_clock_out))
        else $error("clock out not halved");
    cover property (take_valid && take_type == 8'h02);
    cover property ($fell(request_pin_2_or_ack_out_0));
    cover property ($fell(request_pin_3_or_ack_out_1));
endmodule : irq_frontend_monitor

bind irq_frontend irq_frontend_monitor #(.INT_TYPE_BASE(INT_TYPE_BASE)) u_mon (.*);

// ==== dv/irq_source_model.sv ====
// External interrupt sources driving the request pins.
// Assumes raise commands on aclk and the core take strobe.
`timescale 1ns/100ps
module irq_source_model #(
    parameter logic [7:0] INT_TYPE_BASE = 8'h0c
) (
    // Clock, reset, commands
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [4:0] raise,
    // Core take strobe
    input  wire logic       take_valid,
    input  wire logic [7:0] take_type,
    // Pin levels, bit 4 is the non-maskable pin
    output logic      [4:0] pins
);
    logic [2:0] nmi_cnt;
    // ----------
    // Sources
    // ----------
    always @(posedge aclk) begin
        if (!aresetn) begin
            pins    <= 5'h00;
            nmi_cnt <= 3'h0;
        end else begin
            // Dropping before the take would risk a lost request
            for (int i = 0; i < 4; i++) begin
                if (raise[i]) pins[i] <= 1'b1;
                else if (take_valid && take_type == INT_TYPE_BASE + i[7:0]) pins[i] <= 1'b0;
            end
            // Four aclk cycles high, twice the minimum
            nmi_cnt <= raise[4] ? 3'h4 : nmi_cnt - {2'b00, nmi_cnt != 3'h0};
            pins[4] <= raise[4] || nmi_cnt > 3'h1;
        end
    end
endmodule : irq_source_model

// ==== dv/interrupt_request_pin_frontend_bench.sv ====
// Self-checking bench for the interrupt request front end.
// Assumes the source model on the pins.
`timescale 1ns/100ps
module interrupt_request_pin_frontend_bench;
    localparam logic [7:0] BASE = 8'h0c;
    logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic        inst_boundary = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic        take_valid, irq, p2_out, p2_oe, p3_out, p3_oe;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, take_type;
    logic [31:0] wdata = 32'h0, rdata;
    logic [4:0]  raise = 5'h00, src;
    logic [1:0]  bresp, rresp;
    int          n_errors = 0, checked = 0;

    always #2.5 aclk = ~aclk;

    irq_frontend #(.INT_TYPE_BASE(BASE)) i_irq_frontend (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .nmi_pin(src[4]), .request_pin_0(src[0]), .request_pin_1_or_slave_select(src[1]),
        .request_pin_2_in(p2_oe ? p2_out : src[2]), .request_pin_2_or_ack_out_0(p2_out),
        .request_pin_2_oe(p2_oe), .request_pin_3_in(p3_oe ? p3_out : src[3]),
        .request_pin_3_or_ack_out_1(p3_out), .request_pin_3_oe(p3_oe),
        .processor_clock_out(), .inst_boundary(inst_boundary),
        .take_valid(take_valid), .take_type(take_type), .irq(irq));
    irq_source_model #(.INT_TYPE_BASE(BASE)) i_irq_source_model (
        .aclk(aclk), .aresetn(aresetn), .raise(raise),
        .take_valid(take_valid), .take_type(take_type), .pins(src));

    // ----------
    // Tasks
    // ----------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = irq_frontend_pkg::RESP_OKAY);
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'b1;
        wv     <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (awv && !awready || wv && !wready);
        do @(posedge aclk); while (!bvalid);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = irq_frontend_pkg::RESP_OKAY);
        araddr <= a;
        arv    <= 1'b1;
        do @(posedge aclk); while (!arready);
        arv <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        chk(n, e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rc
    // Raise pins, then wait out synchroniser and sampling
    task automatic rs(input logic [4:0] m);
        raise <= m;
        @(posedge aclk);
        raise <= 5'h00;
        repeat (8) @(posedge aclk);
    endtask : rs
    task automatic tk(input string n, input logic [7:0] e);
        int t = 0;
        inst_boundary <= 1'b1;
        @(posedge aclk);
        inst_boundary <= 1'b0;
        do begin
            @(posedge aclk);
            t++;
        end while (!take_valid && t < 20);
        chk(n, {23'h0, 1'b1, e}, {23'h0, take_valid, take_type});
    endtask : tk
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // ----------
    // Tests
    // ----------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        wr(8'h20, 32'hffffffff, irq_frontend_pkg::RESP_SLVERR);
        rc("unmapped", 8'h20, 32'h0, irq_frontend_pkg::RESP_SLVERR);
        rs(5'h10);
        rc("status", irq_frontend_pkg::OFS_STATUS, 32'h10);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(irq_frontend_pkg::OFS_IRQ_MASK, 32'h10);
        @(posedge aclk);
        chk("irq open", 32'h1, {31'h0, irq});
        wr(irq_frontend_pkg::OFS_STATUS, 32'h10);
        chk("irq cleared", 32'h0, {31'h0, irq});
        tk("nmi take", irq_frontend_pkg::NMI_TYPE);
        rc("nmi done", irq_frontend_pkg::OFS_PENDING, 32'h0);
        $display("test nmi done");
        wr(irq_frontend_pkg::OFS_CTRL, 32'h33);
        wr(irq_frontend_pkg::OFS_REQ_ENABLE, 32'h3);
        rs(5'h01);
        tk("req0 take", BASE);
        rc("edge latch", irq_frontend_pkg::OFS_PENDING, 32'h0);
        rs(5'h02);
        tk("req1 take", BASE + 8'h01);
        $display("test ack done");
        wr(irq_frontend_pkg::OFS_CTRL, 32'h0);
        rs(5'h01);
        rc("level pend", irq_frontend_pkg::OFS_PENDING, 32'h1);
        tk("level take", BASE);
        $display("test level done");
        final_report();
    end
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
endmodule : interrupt_request_pin_frontend_bench
